// *** rfq_params.svh ***
// Offsets, field positions, reset values and timing of the ring qualifier
`ifndef RFQ_PARAMS_SVH
`define RFQ_PARAMS_SVH

`define RFQ_CLK_PERIOD_NS 40
`define RFQ_TICK_NS       2000000
`define RFQ_TICK_CYCLES   (`RFQ_TICK_NS / `RFQ_CLK_PERIOD_NS)
`define RFQ_TICK_MS       2
`define RFQ_DLY_A_MS      256
`define RFQ_DLY_B_MS      512
`define RFQ_DLY_C_MS      1792
`define RFQ_DLY_A_TICKS   (`RFQ_DLY_A_MS / `RFQ_TICK_MS)
`define RFQ_DLY_B_TICKS   (`RFQ_DLY_B_MS / `RFQ_TICK_MS)
`define RFQ_DLY_C_TICKS   (`RFQ_DLY_C_MS / `RFQ_TICK_MS)

`define RFQ_IDX_CTRL1     10'h016
`define RFQ_IDX_CTRL2     10'h017
`define RFQ_ADDR_CTRL1    {`RFQ_IDX_CTRL1, 2'h0}
`define RFQ_ADDR_CTRL2    {`RFQ_IDX_CTRL2, 2'h0}
`define RFQ_ADDR_START    12'h100
`define RFQ_ADDR_STATUS   12'h104
`define RFQ_ADDR_MASK     12'h108
`define RFQ_ADDR_TIMER    12'h10C

`define RFQ_CTRL1_RST     8'h96
`define RFQ_CTRL2_RST     8'h2D
`define RFQ_START_RST     6'h19
`define RFQ_STATUS_RST    3'h0
`define RFQ_MASK_RST      3'h0

`define RFQ_DLY_HI_BIT    7
`define RFQ_DLY_LO_MSB    7
`define RFQ_DLY_LO_LSB    6
`define RFQ_LIMIT_MSB     5

`define RFQ_ST_QUAL       0
`define RFQ_ST_FAST       1
`define RFQ_ST_VALID      2

`define RFQ_RESP_OKAY     2'h0
`define RFQ_RESP_SLVERR   2'h2

`endif

// *** rfq_pkg.sv ***
// Types shared by the ring qualifier modules
package rfq_pkg;

  typedef enum logic [3:0] {
    RFQ_IDLE  = 4'h1,
    RFQ_ARMED = 4'h2,
    RFQ_DELAY = 4'h4,
    RFQ_VALID = 4'h8
  } rfq_state_type;

  typedef struct packed {
    logic          ring_s1;
    logic          ring_s2;
    logic          ring_prev;
    rfq_state_type state;
    logic [5:0]    timer;
    logic [7:0]    ctrl1;
    logic          ctrl2_hi;
    logic [5:0]    start;
    logic [2:0]    status;
    logic [2:0]    mask;
    logic          valid_out;
    logic          irq;
    logic          dly_start;
    logic          dly_cancel;
    logic          awready;
    logic          wready;
    logic          aw_have;
    logic          w_have;
    logic [11:0]   awaddr;
    logic [7:0]    wdata;
    logic          wstrb0;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } rfq_main_type;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } rfq_tick_type;

  typedef struct packed {
    logic [9:0] cnt;
    logic       busy;
    logic       done;
  } rfq_dly_type;

endpackage

// *** rfq_tick.sv ***
// Prescaler giving a one-cycle pulse every qualification step
`timescale 1ns/10ps
module rfq_tick #(
  parameter int unsigned TICK_CYCLES = 50000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Step pulse
  output logic      tick
);
  import rfq_pkg::*;

  rfq_tick_type q;
  rfq_tick_type n;

  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (q.cnt >= TICK_CYCLES - 1) begin
      n.cnt  = 32'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;
endmodule

// *** rfq_delay.sv ***
// Delay between ring validation and valid-ring indication
`timescale 1ns/10ps
`include "rfq_params.svh"
module rfq_delay (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       cancel,
  input  wire logic [2:0] code,
  // Expiry pulse
  output logic            done
);
  import rfq_pkg::*;

  rfq_dly_type q;
  rfq_dly_type n;
  logic [9:0]  load;

  always_comb begin
    case (code)
      3'h1:    load = 10'(`RFQ_DLY_A_TICKS);
      3'h2:    load = 10'(`RFQ_DLY_B_TICKS);
      3'h7:    load = 10'(`RFQ_DLY_C_TICKS);
      default: load = 10'h000;
    endcase
  end

  always_comb begin
    n = q;
    n.done = 1'b0;
    if (cancel) begin
      n.busy = 1'b0;
      n.cnt  = 10'h000;
    end else if (start) begin
      n.busy = 1'b1;
      n.cnt  = load;
    end else if (q.busy) begin
      if (q.cnt == 10'h000) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else if (tick) begin
        n.cnt = q.cnt - 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done = q.done;
endmodule

// *** rfq_top.sv ***
// Ring frequency qualifier with AXI4-Lite registers
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`include "rfq_params.svh"
module rfq_top #(
  parameter int unsigned TICK_CYCLES = `RFQ_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // Line event and ring indication
  input  wire logic        RING_EVENT,
  output logic             RING_VALID,
  output logic             IRQ,
  // AXI4-Lite write address
  input  wire logic [11:0] AWADDR,
  input  wire logic [2:0]  AWPROT,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // AXI4-Lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read address
  input  wire logic [11:0] ARADDR,
  input  wire logic [2:0]  ARPROT,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  import rfq_pkg::*;

  rfq_main_type q;
  rfq_main_type n;
  logic         tick;
  logic         dly_done;
  logic [2:0]   dly_code;
  logic         ev;
  logic [5:0]   limit;
  logic         too_fast;
  logic [2:0]   set;
  logic [2:0]   clr;
  logic         do_write;
  logic         wr_ok;

  rfq_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) rfq_tick_inst (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .tick  (tick)
  );

  assign dly_code = {q.ctrl2_hi,
                     q.ctrl1[`RFQ_DLY_LO_MSB:`RFQ_DLY_LO_LSB]};

  rfq_delay rfq_delay_inst (
    .clk    (CLOCK),
    .rst_n  (RST_N),
    .tick   (tick),
    .start  (q.dly_start),
    .cancel (q.dly_cancel),
    .code   (dly_code),
    .done   (dly_done)
  );

  // Rising edge of the synchronised line event
  assign ev       = q.ring_s2 & ~q.ring_prev;
  assign limit    = q.ctrl1[`RFQ_LIMIT_MSB:0];
  assign too_fast = q.timer > limit;
  assign do_write = q.aw_have & q.w_have & ~q.bvalid;

  always_comb begin
    wr_ok = 1'b1;
    case (q.awaddr)
      `RFQ_ADDR_CTRL1:  wr_ok = 1'b1;
      `RFQ_ADDR_CTRL2:  wr_ok = 1'b1;
      `RFQ_ADDR_START:  wr_ok = 1'b1;
      `RFQ_ADDR_STATUS: wr_ok = 1'b1;
      `RFQ_ADDR_MASK:   wr_ok = 1'b1;
      `RFQ_ADDR_TIMER:  wr_ok = 1'b1;
      default:          wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    n = q;
    set = 3'h0;
    clr = 3'h0;
    n.ring_s1    = RING_EVENT;
    n.ring_s2    = q.ring_s1;
    n.ring_prev  = q.ring_s2;
    n.dly_start  = 1'b0;
    n.dly_cancel = 1'b0;

    // Interval timer runs down and holds at zero
    if (tick && q.timer != 6'h00) begin
      n.timer = q.timer - 6'h01;
    end

    if (ev) begin
      n.timer = q.start;
      case (q.state)
        RFQ_IDLE: begin
          n.state = RFQ_ARMED;
        end
        RFQ_ARMED: begin
          if (too_fast) begin
            set[`RFQ_ST_FAST] = 1'b1;
          end else begin
            n.state     = RFQ_DELAY;
            n.dly_start = 1'b1;
            set[`RFQ_ST_QUAL] = 1'b1;
          end
        end
        RFQ_DELAY, RFQ_VALID: begin
          if (too_fast) begin
            n.state      = RFQ_ARMED;
            n.valid_out  = 1'b0;
            n.dly_cancel = 1'b1;
            set[`RFQ_ST_FAST] = 1'b1;
          end else if (q.state == RFQ_DELAY && dly_done) begin
            // Expiry pulse lasts one cycle: keep it when an event that is not too fast comes with it
            n.state     = RFQ_VALID;
            n.valid_out = 1'b1;
            set[`RFQ_ST_VALID] = 1'b1;
          end
        end
        default: begin
          n.state = RFQ_IDLE;
        end
      endcase
    end else if (q.state != RFQ_IDLE && q.timer == 6'h00) begin
      // No further event before the timer ran out: ring is over
      n.state      = RFQ_IDLE;
      n.valid_out  = 1'b0;
      n.dly_cancel = 1'b1;
    end else if (q.state == RFQ_DELAY && dly_done) begin
      n.state     = RFQ_VALID;
      n.valid_out = 1'b1;
      set[`RFQ_ST_VALID] = 1'b1;
    end

    // Write channel: address and data taken in either order
    if (AWVALID && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = AWADDR;
      n.awready = 1'b0;
    end
    if (WVALID && q.wready) begin
      n.w_have = 1'b1;
      n.wdata  = WDATA[7:0];
      n.wstrb0 = WSTRB[0];
      n.wready = 1'b0;
    end
    if (do_write) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_ok ? `RFQ_RESP_OKAY : `RFQ_RESP_SLVERR;
      if (q.wstrb0) begin
        case (q.awaddr)
          `RFQ_ADDR_CTRL1: begin
            n.ctrl1 = q.wdata;
          end
          `RFQ_ADDR_CTRL2: begin
            n.ctrl2_hi = q.wdata[`RFQ_DLY_HI_BIT];
          end
          `RFQ_ADDR_START: begin
            n.start = q.wdata[5:0];
          end
          `RFQ_ADDR_STATUS: begin
            clr = q.wdata[2:0];
          end
          `RFQ_ADDR_MASK: begin
            n.mask = q.wdata[2:0];
          end
          default: begin
            n.bresp = n.bresp;
          end
        endcase
      end
    end
    if (q.bvalid && BREADY) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // Read channel
    if (ARVALID && q.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = `RFQ_RESP_OKAY;
      case (ARADDR)
        `RFQ_ADDR_CTRL1: begin
          n.rdata = {24'h000000, q.ctrl1};
        end
        `RFQ_ADDR_CTRL2: begin
          n.rdata = {24'h000000, q.ctrl2_hi, 7'h00};
        end
        `RFQ_ADDR_START: begin
          n.rdata = {26'h0000000, q.start};
        end
        `RFQ_ADDR_STATUS: begin
          n.rdata = {29'h00000000, q.status};
        end
        `RFQ_ADDR_MASK: begin
          n.rdata = {29'h00000000, q.mask};
        end
        `RFQ_ADDR_TIMER: begin
          n.rdata = {20'h00000, q.state, 2'h0, q.timer};
        end
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = `RFQ_RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && RREADY) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // Sticky events: a new event beats a clear in the same cycle
    n.status = (q.status & ~clr) | set;
    n.irq    = |(n.status & n.mask);
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q          <= '0;
      q.state    <= RFQ_IDLE;
      q.ctrl1    <= `RFQ_CTRL1_RST;
      q.ctrl2_hi <= 1'(`RFQ_CTRL2_RST >> `RFQ_DLY_HI_BIT);
      q.start    <= `RFQ_START_RST;
      q.status   <= `RFQ_STATUS_RST;
      q.mask     <= `RFQ_MASK_RST;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign RING_VALID = q.valid_out;
  assign IRQ        = q.irq;
  assign AWREADY    = q.awready;
  assign WREADY     = q.wready;
  assign BVALID     = q.bvalid;
  assign BRESP      = q.bresp;
  assign ARREADY    = q.arready;
  assign RVALID     = q.rvalid;
  assign RDATA      = q.rdata;
  assign RRESP      = q.rresp;
endmodule

// *** rfq_top_assertions.sv ***
// Bus and register checks for the ring qualifier
`timescale 1ns/10ps
module rfq_chk (
  // Clock and reset
  input logic        CLOCK,
  input logic        RST_N,
  // Write channels
  input logic        AWVALID,
  input logic        AWREADY,
  input logic        WVALID,
  input logic        WREADY,
  input logic [1:0]  BRESP,
  input logic        BVALID,
  input logic        BREADY,
  // Read channels
  input logic [11:0] ARADDR,
  input logic        ARVALID,
  input logic        ARREADY,
  input logic [31:0] RDATA,
  input logic [1:0]  RRESP,
  input logic        RVALID,
  input logic        RREADY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID &&
    $stable(BRESP)) else $error("write response dropped");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID &&
    $stable(RDATA)) else $error("read data dropped");
  a_write_walk: assert property (AWVALID && AWREADY && WVALID &&
    WREADY |=> !AWREADY && !WREADY ##1 BVALID) else $error("bad write");
  a_read_next: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_read_busy: assert property (RVALID |-> !ARREADY)
    else $error("second read taken");
  a_unmapped_rd: assert property (ARVALID && ARREADY &&
    ARADDR == 12'h000 |=> RRESP == 2'h2 && RDATA == 32'h0)
    else $error("unmapped read answered");
  a_ctrl2_bits: assert property (ARVALID && ARREADY &&
    ARADDR == 12'h05C |=> RDATA[31:8] == 24'h0 && RDATA[6:0] == 7'h0)
    else $error("stray control bits");
  a_timer_view: assert property (ARVALID && ARREADY &&
    ARADDR == 12'h10C |=> $onehot(RDATA[11:8]) && RDATA[7:6] == 2'h0)
    else $error("bad timer view");
endmodule

bind rfq_top rfq_chk rfq_chk_inst (.CLOCK(CLOCK), .RST_N(RST_N),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
  .RVALID(RVALID), .RREADY(RREADY));

// *** tb_ring_frequency_qualifier.sv ***
// Self-checking bench for the ring frequency qualifier
`timescale 1ns/10ps
module tb_ring_frequency_qualifier;
  import rfq_pkg::*;
  localparam int T = 4;
  // Computed limit plus one of margin
  localparam int LIM = 9 + 1;
  logic        CLOCK = 0, RST_N = 0, RING_EVENT = 0;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0;
  logic        ARVALID = 0, RREADY = 0;
  logic [11:0] AWADDR = 0, ARADDR = 0;
  logic [2:0]  AWPROT = 0, ARPROT = 0;
  logic [31:0] WDATA = 0;
  logic [3:0]  WSTRB = 4'hF;
  logic        RING_VALID, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA;
  int          fail_count = 0, cmp_count = 0, cyc = 0, gap = 0, ecnt = 0;
  int          ev_n = 0, last_ev = 0, seed = 32'h0e66, st, lo, t, i;
  int          cd[4] = '{0, 1, 2, 7};
  int          dq[4] = '{0, 128, 256, 896};
  rfq_top #(.TICK_CYCLES(T)) rfq_top_inst (.*);
  always #20 CLOCK = ~CLOCK;
  // Periodic line events and run ceiling
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    ecnt <= (ecnt >= gap) ? 0 : ecnt + 1;
    RING_EVENT <= (gap != 0) && (ecnt < 2);
    if (gap != 0 && ecnt == 0) begin
      ev_n <= ev_n + 1;
      last_ev <= cyc;
    end
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("ERROR %s expected %0h seen %0h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw, w;
    logic [31:0] r;
    @(posedge CLOCK);
    aw = 0;
    w = 0;
    r = $random(seed);
    AWADDR <= a;
    WDATA <= {r[31:8], d};
    AWVALID <= 1;
    WVALID <= 1;
    while (!(aw && w)) begin
      @(posedge CLOCK);
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 0;
      end
    end
    // Late acceptance exercises the response hold checks
    repeat (r[1:0]) @(posedge CLOCK);
    BREADY <= 1;
    do @(posedge CLOCK); while (!BVALID);
    BREADY <= 0;
    chk("bresp", er, BRESP);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] r;
    @(posedge CLOCK);
    r = $random(seed);
    ARADDR <= a;
    ARVALID <= 1;
    do @(posedge CLOCK); while (!ARREADY);
    ARVALID <= 0;
    // Late acceptance exercises the read data hold check
    repeat (r[1:0]) @(posedge CLOCK);
    RREADY <= 1;
    do @(posedge CLOCK); while (!RVALID);
    RREADY <= 0;
    chk("rdata", e, RDATA);
    chk("rresp", er, RRESP);
  endtask
  // Arm with one event, qualify with the next, time the indication
  task automatic ring(input int g, output int t);
    int b;
    b = ev_n;
    gap <= g;
    while (ev_n < b + 2) @(posedge CLOCK);
    t = 0;
    while (RING_VALID !== 1 && t < 5000) begin
      @(posedge CLOCK);
      t++;
    end
  endtask
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1;
    rd(12'h058, 32'h96, 0);
    rd(12'h05C, 0, 0);
    rd(12'h100, 32'h19, 0);
    rd(12'h104, 0, 0);
    rd(12'h108, 0, 0);
    rd(12'h10C, 32'h100, 0);
    wr(12'h05C, 8'hFF, 0);
    rd(12'h05C, 32'h80, 0);
    wr(12'h10C, 8'hFF, 0);
    rd(12'h10C, 32'h100, 0);
    wr(12'h000, 8'hFF, 2);
    rd(12'h000, 0, 2);
    WSTRB <= 4'hE;
    wr(12'h100, 8'h3F, 0);
    WSTRB <= 4'hF;
    rd(12'h100, 32'h19, 0);
    st = 20 + ($random(seed) & 3);
    wr(12'h100, st[7:0], 0);
    for (i = 0; i < 4; i++) begin
      wr(12'h05C, {cd[i][2], 7'h0}, 0);
      wr(12'h058, {cd[i][1:0], LIM[5:0]}, 0);
      ring((st - LIM + 3) * T, t);
      lo = dq[i] * T;
      chk("ring_delay", 1, t >= lo && t <= lo + T + 12);
      gap <= 0;
      while (RING_VALID === 1) @(posedge CLOCK);
      t = cyc - last_ev;
      chk("ring_end", 1, t >= (st - 1) * T && t <= (st + 1) * T + 12);
      chk("irq_masked", 0, IRQ);
      rd(12'h104, 5, 0);
      wr(12'h104, 7, 0);
    end
    wr(12'h108, 2, 0);
    wr(12'h05C, 0, 0);
    wr(12'h058, {2'h0, LIM[5:0]}, 0);
    ring((st - LIM + 3) * T, t);
    gap <= 3 * T;
    repeat (8 * T) @(posedge CLOCK);
    chk("fast_drop", 0, RING_VALID);
    chk("irq_set", 1, IRQ);
    gap <= 0;
    repeat ((st + 10) * T) @(posedge CLOCK);
    rd(12'h104, 7, 0);
    wr(12'h104, 2, 0);
    chk("irq_clear", 0, IRQ);
    rd(12'h104, 5, 0);
    wr(12'h108, 0, 0);
    stop_test();
  end
endmodule
